// ---- gmc_top.sv ----
module gmc_top (
   input wire logic clk,
   input wire logic nrst,
   input wire gmc_pkg::gmc_req_t req,
   output logic [15:0] rdata,
   output logic rvalid,
   input wire logic signed [15:0] thermistor_input,
   input wire logic signed [15:0] raw_current,
   input wire logic [15:0] cell_voltage,
   input wire gmc_pkg::gmc_learn_t learn_in,
   output logic signed [15:0] temperature,
   output logic signed [15:0] current,
   output logic empty_flag,
   output logic empty_detect_armed,
   output gmc_pkg::gmc_lmode_t learn_mode,
   output logic [7:0] nominal_resist_comp,
   output logic [7:0] hot_slope_coef,
   output logic [7:0] cold_slope_coef
);
   import gmc_pkg::*;

   logic [15:0] temp_gain_q;
   logic [15:0] temp_off_q;
   logic [15:0] cur_gain_q;
   logic [15:0] cur_off_q;
   logic [15:0] qr20_q;
   logic [15:0] qr30_q;
   logic [15:0] iavg_q;
   logic [15:0] slope_q;
   logic [7:0] rcomp_q;
   logic [8:0] empty_v_q;
   logic [6:0] vrecov_q;
   logic signed [15:0] temp_d;
   logic signed [15:0] cur_d;
   logic [15:0] rdata_d;
   logic armed_q;
   logic empty_q;
   logic [15:0] empty_v_mv;
   logic [15:0] vrecov_mv;
   gmc_lmode_t lmode_d;
   logic signed [15:0] qr20_d;
   logic signed [15:0] qr30_d;
   logic wr_temp_gain;
   logic wr_temp_off;
   logic wr_cur_gain;
   logic wr_cur_off;
   logic wr_table20;
   logic wr_table30;
   logic wr_avg_empty;
   logic wr_resist;
   logic wr_slope;
   logic wr_thresh;

   // signed multiply, scale by 2^-14, add doubled offset, saturate
   function automatic logic signed [15:0] correct(input logic signed [15:0] x,
                                                  input logic signed [15:0] g,
                                                  input logic signed [15:0] o);
      logic signed [31:0] prod;
      logic signed [33:0] sum;
      prod = x * g;
      sum = 34'(prod >>> GAIN_SHIFT) + 34'(o) * 34'sd2;
      if (sum > 34'(S16_MAX))
         correct = S16_MAX;
      else if (sum < 34'(S16_MIN))
         correct = S16_MIN;
      else
         correct = sum[15:0];
   endfunction

   function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
      logic signed [16:0] s;
      s = 17'(a) + 17'(b);
      if (s > 17'(S16_MAX))
         sat_add = S16_MAX;
      else if (s < 17'(S16_MIN))
         sat_add = S16_MIN;
      else
         sat_add = s[15:0];
   endfunction

   // write address decode
   always_comb
   begin
      wr_temp_gain = req.wr && req.addr == ADDR_TEMP_GAIN;
      wr_temp_off = req.wr && req.addr == ADDR_TEMP_OFFSET;
      wr_cur_gain = req.wr && req.addr == ADDR_CUR_GAIN;
      wr_cur_off = req.wr && req.addr == ADDR_CUR_OFFSET;
      wr_table20 = req.wr && req.addr == ADDR_QR20;
      wr_table30 = req.wr && req.addr == ADDR_QR30;
      wr_avg_empty = req.wr && req.addr == ADDR_IAVG;
      wr_resist = req.wr && req.addr == ADDR_RCOMP;
      wr_slope = req.wr && req.addr == ADDR_SLOPE_COEF;
      wr_thresh = req.wr && req.addr == ADDR_THRESHOLDS;
   end

   // register writes
   always_ff @(posedge clk)
   begin
      if (!nrst)
         temp_gain_q <= RST_TEMP_GAIN;
      else if (wr_temp_gain)
         temp_gain_q <= req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         temp_off_q <= RST_TEMP_OFFSET;
      else if (wr_temp_off)
         temp_off_q <= req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         cur_gain_q <= RST_CUR_GAIN;
      else if (wr_cur_gain)
         cur_gain_q <= req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         cur_off_q <= RST_CUR_OFFSET;
      else if (wr_cur_off)
         cur_off_q <= req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         iavg_q <= RST_ZERO;
      else if (wr_avg_empty)
         iavg_q <= req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         rcomp_q <= RST_ZERO[RCOMP_MSB:0];
      else if (wr_resist)
         rcomp_q <= req.wdata[RCOMP_MSB:0];
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         slope_q <= RST_ZERO;
      else if (wr_slope)
         slope_q <= req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         empty_v_q <= RST_EMPTY_V_FLD;
         vrecov_q <= RST_VRECOV_FLD;
      end
      else if (wr_thresh)
      begin
         empty_v_q <= req.wdata[EMPTY_V_MSB:EMPTY_V_LSB];
         vrecov_q <= req.wdata[VRECOV_MSB:0];
      end
   end

   // learning mode from pivot comparison
   always_comb
   begin
      lmode_d = LEARN_MIXED;
      if (!learn_in.learn)
         lmode_d = LEARN_NONE;
      else if (32'(learn_in.current) > (32'(signed'(iavg_q)) <<< PIVOT_SHIFT))
         lmode_d = LEARN_GAIN;
      else if ((32'(learn_in.current) <<< PIVOT_SHIFT) < 32'(signed'(iavg_q)))
         lmode_d = LEARN_OFFSET;
   end

   // split the error across the two neighbouring entries
   always_comb
   begin
      qr20_d = sat_add(signed'(qr20_q), learn_in.error >>> 1);
      qr30_d = sat_add(signed'(qr30_q), learn_in.error - (learn_in.error >>> 1));
   end

   // compensation table: a software write wins over learning for its own entry only
   always_ff @(posedge clk)
   begin
      if (!nrst)
         qr20_q <= RST_ZERO;
      else if (wr_table20)
         qr20_q <= req.wdata;
      else if (learn_in.learn)
         qr20_q <= qr20_d;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         qr30_q <= RST_ZERO;
      else if (wr_table30)
         qr30_q <= req.wdata;
      else if (learn_in.learn)
         qr30_q <= qr30_d;
   end

   // corrected results
   always_comb
   begin
      temp_d = correct(thermistor_input, signed'(temp_gain_q),
                       signed'(temp_off_q));
      cur_d = correct(raw_current, signed'(cur_gain_q), signed'(cur_off_q));
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         temperature <= RST_ZERO;
         current <= RST_ZERO;
         learn_mode <= LEARN_NONE;
      end
      else
      begin
         temperature <= temp_d;
         current <= cur_d;
         learn_mode <= lmode_d;
      end
   end

   // empty detection with recovery hysteresis, empty threshold in 10 mv steps, recovery threshold in 40 mv steps
   always_comb
   begin
      empty_v_mv = 16'(empty_v_q);
      vrecov_mv = 16'(vrecov_q) << VRECOV_SCALE_SHIFT;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         armed_q <= 1'b1;
         empty_q <= 1'b0;
      end
      else if (armed_q && cell_voltage < empty_v_mv)
      begin
         armed_q <= 1'b0;
         empty_q <= 1'b1;
      end
      else if (!armed_q && cell_voltage > vrecov_mv)
      begin
         armed_q <= 1'b1;
         empty_q <= 1'b0;
      end
   end

   // read mux
   always_comb
   begin
      case (req.addr)
         ADDR_TEMP_GAIN: rdata_d = temp_gain_q;
         ADDR_TEMP_OFFSET: rdata_d = temp_off_q;
         ADDR_CUR_GAIN: rdata_d = cur_gain_q;
         ADDR_CUR_OFFSET: rdata_d = cur_off_q;
         ADDR_QR20: rdata_d = qr20_q;
         ADDR_IAVG: rdata_d = iavg_q;
         ADDR_RCOMP: rdata_d = {8'h00, rcomp_q};
         ADDR_SLOPE_COEF: rdata_d = slope_q;
         ADDR_THRESHOLDS: rdata_d = {empty_v_q, vrecov_q};
         ADDR_QR30: rdata_d = qr30_q;
         default: rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end
      else
      begin
         rdata <= req.rd ? rdata_d : 16'h0000;
         rvalid <= req.rd;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         empty_flag <= 1'b0;
         empty_detect_armed <= 1'b1;
         nominal_resist_comp <= 8'h00;
         hot_slope_coef <= 8'h00;
         cold_slope_coef <= 8'h00;
      end
      else
      begin
         empty_flag <= empty_q;
         empty_detect_armed <= armed_q;
         nominal_resist_comp <= rcomp_q;
         hot_slope_coef <= slope_q[15:8];
         cold_slope_coef <= slope_q[7:0];
      end
   end
endmodule

// ---- gmc_pkg.sv ----
package gmc_pkg;
   localparam logic [7:0] ADDR_TEMP_GAIN = 8'h2c;
   localparam logic [7:0] ADDR_TEMP_OFFSET = 8'h2d;
   localparam logic [7:0] ADDR_CUR_GAIN = 8'h2e;
   localparam logic [7:0] ADDR_CUR_OFFSET = 8'h2f;
   localparam logic [7:0] ADDR_QR20 = 8'h32;
   localparam logic [7:0] ADDR_IAVG = 8'h36;
   localparam logic [7:0] ADDR_RCOMP = 8'h38;
   localparam logic [7:0] ADDR_SLOPE_COEF = 8'h39;
   localparam logic [7:0] ADDR_THRESHOLDS = 8'h3a;
   localparam logic [7:0] ADDR_QR30 = 8'h42;
   localparam logic [15:0] RST_TEMP_GAIN = 16'h0000;
   localparam logic [15:0] RST_TEMP_OFFSET = 16'h0000;
   localparam logic [15:0] RST_CUR_GAIN = 16'h4000;
   localparam logic [15:0] RST_CUR_OFFSET = 16'h0000;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   // 3.12 v / 10 mv = 312, 3.68 v / 40 mv = 92
   localparam logic [8:0] RST_EMPTY_V_FLD = 9'h138;
   localparam logic [6:0] RST_VRECOV_FLD = 7'h5c;
   localparam int EMPTY_V_MSB = 15;
   localparam int EMPTY_V_LSB = 7;
   localparam int VRECOV_MSB = 6;
   localparam int RCOMP_MSB = 7;
   localparam int GAIN_SHIFT = 14;
   // cell voltage input lsb assumed 10 mv; recovery field is 4x that
   localparam int VRECOV_SCALE_SHIFT = 2;
   // "far" from the pivot: more than 2x or less than half
   localparam int PIVOT_SHIFT = 1;
   localparam logic signed [15:0] S16_MAX = 16'sh7fff;
   localparam logic signed [15:0] S16_MIN = -16'sh8000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } gmc_req_t;

   typedef struct packed {
      logic learn;
      logic signed [15:0] current;
      logic signed [15:0] error;
   } gmc_learn_t;

   typedef enum logic [1:0] {LEARN_NONE, LEARN_GAIN, LEARN_OFFSET, LEARN_MIXED} gmc_lmode_t;
endpackage

// ---- gmc_assertions.sv ----
module gmc_assertions (
   input wire logic clk,
   input wire logic nrst,
   input wire gmc_pkg::gmc_req_t req,
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   input wire logic signed [15:0] thermistor_input,
   input wire logic signed [15:0] raw_current,
   input wire logic [15:0] cell_voltage,
   input wire gmc_pkg::gmc_learn_t learn_in,
   input wire logic signed [15:0] temperature,
   input wire logic signed [15:0] current,
   input wire logic empty_flag,
   input wire logic empty_detect_armed,
   input wire gmc_pkg::gmc_lmode_t learn_mode,
   input wire logic [7:0] hot_slope_coef,
   input wire logic [7:0] cold_slope_coef
);
   import gmc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   rd_answer_a: assert property (req.rd |=> rvalid)
      else $error("read not answered");
   rd_idle_a: assert property (!req.rd |=> !rvalid && rdata == 16'h0000)
      else $error("read answer without a read");
   cur_hold_a: assert property (
      (!req.wr && $stable(raw_current))[*2] |=> $stable(current))
      else $error("current moved with steady inputs");
   tmp_hold_a: assert property (
      (!req.wr && $stable(thermistor_input))[*2] |=> $stable(temperature))
      else $error("temperature moved with steady inputs");
   empty_low_a: assert property (
      $rose(empty_flag) |-> $past(cell_voltage, 2) < 16'h0200)
      else $error("empty flagged above any threshold");
   rearm_high_a: assert property (
      !empty_detect_armed && cell_voltage > 16'h01ff |-> ##[1:2] empty_detect_armed)
      else $error("detection not re-armed");
   learn_on_a: assert property (learn_in.learn |=> learn_mode != LEARN_NONE)
      else $error("learn event without a mode");
   slope_copy_a: assert property (
      req.wr && req.addr == ADDR_SLOPE_COEF
         |-> ##2 {hot_slope_coef, cold_slope_coef} == $past(req.wdata, 2))
      else $error("slope coefficients not updated");
   cover property ($rose(empty_flag));
   cover property ($rose(empty_detect_armed));
   cover property (learn_mode == LEARN_OFFSET);
endmodule
bind gmc_top gmc_assertions u_chk (.clk, .nrst, .req, .rdata, .rvalid, .thermistor_input,
   .raw_current, .cell_voltage, .learn_in, .temperature, .current, .empty_flag,
   .empty_detect_armed, .learn_mode, .hot_slope_coef, .cold_slope_coef);

// ---- tb_gauge_measurement_calibration.sv ----
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_gauge_measurement_calibration;
   timeunit 1ns;
   timeprecision 1ns;
   import gmc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   gmc_req_t req = '0;
   gmc_learn_t lin = '0;
   logic signed [15:0] th = 16'h0000;
   logic signed [15:0] rc = 16'h0000;
   logic [15:0] cv = 16'h0190;
   logic [15:0] rdata;
   logic signed [15:0] temperature;
   logic signed [15:0] current;
   logic rvalid, ef, arm;
   gmc_lmode_t lm;
   logic [7:0] nrc, hot, cold;
   int miscompares = 0;
   int comparisons = 0;
   always #10 clk = ~clk;
   gmc_top u_dut (.clk, .nrst, .req, .rdata, .rvalid, .thermistor_input(th), .raw_current(rc),
      .cell_voltage(cv), .learn_in(lin), .temperature, .current, .empty_flag(ef),
      .empty_detect_armed(arm), .learn_mode(lm), .nominal_resist_comp(nrc),
      .hot_slope_coef(hot), .cold_slope_coef(cold));
   task test_done();
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge clk) req <= '0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk) req <= '0;
      #1 `CHK({rvalid, rdata}, {1'b1, e});
   endtask
   // floor shift, doubled offset, clamp to 16 bits
   function automatic logic signed [15:0] fix(input logic signed [15:0] x, g, o);
      logic signed [33:0] p;
      p = ((x * g) >>> 14) + 2 * o;
      if (p > 34'sh00007fff)
         return 16'sh7fff;
      if (p < -34'sh00008000)
         return 16'sh8000;
      return p[15:0];
   endfunction
   task corr(input logic signed [15:0] x, g, o);
      wr(ADDR_TEMP_GAIN, g);
      wr(ADDR_TEMP_OFFSET, o);
      wr(ADDR_CUR_GAIN, g);
      wr(ADDR_CUR_OFFSET, o);
      @(posedge clk) th <= x;
      rc <= x;
      repeat (2) @(posedge clk);
      #1 `CHK(temperature, fix(x, g, o));
      `CHK(current, fix(x, g, o));
   endtask
   task vset(input logic [15:0] v, input logic a);
      @(posedge clk) cv <= v;
      repeat (3) @(posedge clk);
      #1 `CHK(arm, a);
   endtask
   task lrn(input logic [15:0] c, e, input gmc_lmode_t m);
      @(posedge clk) lin <= '{1'b1, c, e};
      @(posedge clk) lin <= '0;
      #1 `CHK(lm, m);
   endtask
   initial
   begin
      #100us;
      miscompares++;
      test_done();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd(ADDR_CUR_GAIN, 16'h4000);
      rd(ADDR_CUR_OFFSET, 16'h0000);
      rd(ADDR_THRESHOLDS, {9'h138, 7'h5c});
      rd(8'h30, 16'h0000);
      wr(ADDR_RCOMP, 16'hffa5);
      rd(ADDR_RCOMP, 16'h00a5);
      `CHK(nrc, 8'ha5);
      wr(ADDR_SLOPE_COEF, 16'h1234);
      rd(ADDR_SLOPE_COEF, 16'h1234);
      `CHK({hot, cold}, 16'h1234);
      corr(16'sh0064, 16'sh4000, 16'sh0001);
      corr(16'sh0064, 16'shc000, 16'shfffd);
      corr(16'shfff9, 16'sh2000, 16'sh0000);
      corr(16'sh7fff, 16'sh7fff, 16'sh7fff);
      corr(16'sh8000, 16'sh7fff, 16'sh8000);
      vset(16'h0137, 1'b0);
      `CHK(ef, 1'b1);
      vset(16'h0170, 1'b0);
      vset(16'h0171, 1'b1);
      `CHK(ef, 1'b0);
      wr(ADDR_THRESHOLDS, {9'h0c8, 7'h3c});
      vset(16'h00c8, 1'b1);
      vset(16'h00c7, 1'b0);
      vset(16'h00f1, 1'b1);
      vset(16'h0064, 1'b0);
      vset(16'h0258, 1'b1);
      wr(ADDR_IAVG, 16'h0064);
      rd(ADDR_IAVG, 16'h0064);
      lrn(16'h012c, 16'h0005, LEARN_GAIN);
      lrn(16'h000a, 16'h0000, LEARN_OFFSET);
      lrn(16'h0096, 16'h0000, LEARN_MIXED);
      rd(ADDR_QR20, 16'h0002);
      rd(ADDR_QR30, 16'h0003);
      test_done();
   end
endmodule
